// *** common/isd_pkg.sv ***
package isd_pkg;

  // ****************************************************************
  // Register map (byte addresses on APB)
  // ****************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_SLAVE_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_ONE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_BUS_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DATA_IO = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_TWO = 8'h10;

  // ****************************************************************
  // Field positions and masks
  // ****************************************************************
  localparam int unsigned ST_XFER_DONE = 7;
  localparam int unsigned ST_SLAVE_ADDRESSED = 6;
  localparam int unsigned ST_BUSY = 5;
  localparam int unsigned ST_ARB_LOST = 4;
  localparam int unsigned ST_UNUSED = 3;
  localparam int unsigned ST_SLAVE_DIR = 2;
  localparam int unsigned ST_IRQ_PENDING = 1;
  localparam int unsigned ST_ACK_RECEIVED_N = 0;

  localparam int unsigned C1_MASTER_SELECT = 5;
  localparam int unsigned C1_DIR_TX = 4;
  localparam int unsigned C1_NO_ACK = 3;
  localparam logic [7:0] C1_WR_MASK = 8'h38;

  localparam int unsigned C2_GENERAL_CALL_ENABLE = 7;
  localparam int unsigned C2_ADDR_WIDTH_SELECT = 6;
  localparam int unsigned C2_AD_MSB = 2;
  localparam int unsigned C2_AD_LSB = 0;
  localparam logic [7:0] C2_WR_MASK = 8'hC7;

  localparam logic [7:0] SA_WR_MASK = 8'hFE;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // ****************************************************************
  // Bus constants
  // ****************************************************************
  localparam logic [7:0] GENERAL_CALL_ADDR = 8'h00;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_ACK_END = 4'h9;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CORE_CLK_MHZ = 125;
  localparam int unsigned SCL_HALF_NS = 5000;
  localparam int unsigned SCL_HALF_CYC = (SCL_HALF_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int unsigned TMR_W = 12;

  typedef enum logic [3:0] {
    S_IDLE,
    M_START,
    M_WAIT,
    M_LOW,
    M_HIGH,
    M_STOP_A,
    M_STOP_B,
    S_ADDR,
    S_DATA,
    S_HOLD,
    S_IGNORE
  } isd_state_e;

endpackage

// *** rtl/isd_line_mon.sv ***
module isd_line_mon (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_s,
  output logic sda_s,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_det,
  output logic stop_det
);

  // ****************************************************************
  // Two-stage synchronisers plus one delay stage for edges
  // ****************************************************************
  logic scl_meta;
  logic sda_meta;
  logic scl_d;
  logic sda_d;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      scl_meta <= 1'b1;
      sda_meta <= 1'b1;
      scl_s <= 1'b1;
      sda_s <= 1'b1;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_meta <= scl_i;
      sda_meta <= sda_i;
      scl_s <= scl_meta;
      sda_s <= sda_meta;
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  // Data moving while the clock stays high marks start or stop
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

endmodule // isd_line_mon

// *** rtl/isd_regs_top.sv ***
module isd_regs_top
  import isd_pkg::*;
#(
  parameter int unsigned SCL_HALF = SCL_HALF_CYC
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  isd_state_e state;
  logic [7:0] slave_addr;
  logic [7:0] control_one;
  logic [7:0] control_two;
  logic [7:0] rx_data;
  logic [7:0] shift;
  logic [3:0] bit_cnt;
  logic [TMR_W-1:0] tmr;
  logic tx_mode;
  logic addr_phase;
  logic ext_phase;
  logic cont_pend;
  logic mst_prev;
  logic xfer_done_flag;
  logic slave_addressed_flag;
  logic bus_busy;
  logic arb_lost_flag;
  logic slave_dir_flag;
  logic irq_pending_flag;
  logic ack_received_n;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  localparam logic [TMR_W-1:0] TMR_RELOAD = TMR_W'(SCL_HALF - 1);
  localparam logic [TMR_W-1:0] TMR_SAMPLE = TMR_W'(SCL_HALF / 2);

  function automatic logic [7:0] shift_in(input logic [7:0] cur, input logic bit_in);
    shift_in = {cur[6:0], bit_in};
  endfunction

  isd_line_mon u_line_mon (
    .core_clk(core_clk),
    .srst(srst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det)
  );

  // ****************************************************************
  // APB decode
  // ****************************************************************
  wire acc = psel & penable;
  wire wr_en = acc & pwrite;
  wire rd_en = acc & ~pwrite;
  wire sel_sa = paddr == OFS_SLAVE_ADDR;
  wire sel_c1 = paddr == OFS_CONTROL_ONE;
  wire sel_st = paddr == OFS_BUS_STATUS;
  wire sel_dat = paddr == OFS_DATA_IO;
  wire sel_c2 = paddr == OFS_CONTROL_TWO;
  wire mapped = sel_sa | sel_c1 | sel_st | sel_dat | sel_c2;
  wire wr_c1 = wr_en & sel_c1;
  wire wr_st = wr_en & sel_st;

  wire master_select = control_one[C1_MASTER_SELECT];
  wire dir_tx = control_one[C1_DIR_TX];
  wire mst_rise = master_select & ~mst_prev;
  wire mst_fall = ~master_select & mst_prev;
  wire go_tx = wr_en & sel_dat & dir_tx;
  wire go_rx = rd_en & sel_dat & ~dir_tx;

  wire [7:0] status_byte;
  assign status_byte[ST_XFER_DONE] = xfer_done_flag;
  assign status_byte[ST_SLAVE_ADDRESSED] = slave_addressed_flag;
  assign status_byte[ST_BUSY] = bus_busy;
  assign status_byte[ST_ARB_LOST] = arb_lost_flag;
  assign status_byte[ST_UNUSED] = 1'b0;
  assign status_byte[ST_SLAVE_DIR] = slave_dir_flag;
  assign status_byte[ST_IRQ_PENDING] = irq_pending_flag;
  assign status_byte[ST_ACK_RECEIVED_N] = ack_received_n;

  wire [7:0] rd_byte = sel_sa ? slave_addr :
                       sel_c1 ? control_one :
                       sel_st ? status_byte :
                       sel_dat ? rx_data :
                       sel_c2 ? control_two : RESET_BYTE;

  assign prdata = {24'h000000, rd_byte};
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

  // ****************************************************************
  // Address matching
  // ****************************************************************
  wire ext_mode = control_two[C2_ADDR_WIDTH_SELECT];
  wire [9:0] addr10 = {control_two[C2_AD_MSB:C2_AD_LSB], slave_addr[7:1]};
  wire gc_hit = control_two[C2_GENERAL_CALL_ENABLE] & (shift == GENERAL_CALL_ADDR) & ~ext_phase;
  wire seven_hit = shift[7:1] == slave_addr[7:1];
  wire ten_first_hit = ~ext_phase & (shift[7:1] == {TEN_BIT_PREFIX, addr10[9:8]});
  wire ten_second_hit = ext_phase & (shift == addr10[7:0]);
  wire addr_hit = gc_hit | (ext_mode ? (ten_first_hit | ten_second_hit) : seven_hit);
  wire ten_cont = ext_mode & ten_first_hit & ~gc_hit;

  // ****************************************************************
  // Event terms
  // ****************************************************************
  wire tmr_zero = tmr == '0;
  wire in_master = (state == M_START) | (state == M_WAIT) | (state == M_LOW) | (state == M_HIGH) |
                   (state == M_STOP_A) | (state == M_STOP_B);
  wire hold_high = ((state == M_HIGH) | (state == M_STOP_B)) & ~scl_s;
  wire m_sample = (state == M_HIGH) & scl_s & (tmr == TMR_SAMPLE);
  wire m_high_end = (state == M_HIGH) & scl_s & tmr_zero;
  wire arb_bit_lost = m_sample & tx_mode & (bit_cnt != BIT_ACK) & ~sda_oe & ~sda_s;
  wire arb_start_lost = mst_rise & ~in_master & ~((state == S_IDLE) & ~bus_busy & ~start_det);
  wire ev_arb = arb_bit_lost | arb_start_lost;
  wire slave_byte = (state == S_ADDR) | (state == S_DATA);
  wire s_fall_ack = slave_byte & scl_fall & (bit_cnt == BIT_ACK);
  wire s_fall_end = slave_byte & scl_fall & (bit_cnt == BIT_ACK_END);
  wire ev_match = (state == S_ADDR) & scl_fall & (bit_cnt == BIT_ACK_END) & ~cont_pend;
  wire ev_byte_done = (m_high_end & (bit_cnt == BIT_ACK)) | ((state == S_DATA) & s_fall_end);

  // ****************************************************************
  // Software registers
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      slave_addr <= RESET_BYTE;
      control_one <= RESET_BYTE;
      control_two <= RESET_BYTE;
      mst_prev <= 1'b0;
    end else begin
      mst_prev <= master_select;
      if (wr_en & sel_sa) begin
        slave_addr <= pwdata[7:0] & SA_WR_MASK;
      end
      if (wr_en & sel_c2) begin
        control_two <= pwdata[7:0] & C2_WR_MASK;
      end
      if (wr_c1) begin
        control_one <= pwdata[7:0] & C1_WR_MASK;
      end
      if (ev_arb) begin
        control_one[C1_MASTER_SELECT] <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Status flags: a hardware set wins over a same-cycle clear
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      xfer_done_flag <= 1'b0;
      slave_addressed_flag <= 1'b0;
      bus_busy <= 1'b0;
      arb_lost_flag <= 1'b0;
      slave_dir_flag <= 1'b0;
      irq_pending_flag <= 1'b0;
    end else begin
      xfer_done_flag <= ev_byte_done | ev_match | (xfer_done_flag & ~(go_tx | go_rx));
      slave_addressed_flag <= ev_match | (slave_addressed_flag & ~wr_c1);
      bus_busy <= start_det | (bus_busy & ~stop_det);
      arb_lost_flag <= ev_arb | (arb_lost_flag & ~(wr_st & pwdata[ST_ARB_LOST]));
      irq_pending_flag <= ev_byte_done | ev_match | ev_arb |
                          (irq_pending_flag & ~(wr_st & pwdata[ST_IRQ_PENDING]));
      if ((state == S_ADDR) & s_fall_ack & addr_hit & ~ext_phase) begin
        slave_dir_flag <= shift[0];
      end
    end
  end

  // ****************************************************************
  // Byte engine: master and slave
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= S_IDLE;
      shift <= RESET_BYTE;
      rx_data <= RESET_BYTE;
      bit_cnt <= '0;
      tmr <= '0;
      tx_mode <= 1'b0;
      addr_phase <= 1'b0;
      ext_phase <= 1'b0;
      cont_pend <= 1'b0;
      ack_received_n <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      if (hold_high) begin
        tmr <= TMR_RELOAD;
      end else if (!tmr_zero) begin
        tmr <= tmr - 1'b1;
      end
      case (state)
        S_IDLE: begin
          scl_oe <= 1'b0;
          sda_oe <= 1'b0;
          if (start_det) begin
            state <= S_ADDR;
            bit_cnt <= '0;
            ext_phase <= 1'b0;
            cont_pend <= 1'b0;
          end else if (mst_rise && !bus_busy) begin
            state <= M_START;
            sda_oe <= 1'b1;
            tmr <= TMR_RELOAD;
            addr_phase <= 1'b1;
          end
        end
        M_START: begin
          if (tmr_zero) begin
            scl_oe <= 1'b1;
            state <= M_WAIT;
          end
        end
        M_WAIT: begin
          sda_oe <= 1'b0;
          if (mst_fall) begin
            state <= M_STOP_A;
            sda_oe <= 1'b1;
            tmr <= TMR_RELOAD;
          end else if (go_tx) begin
            shift <= pwdata[7:0];
            tx_mode <= 1'b1;
            bit_cnt <= '0;
            state <= M_LOW;
            tmr <= TMR_RELOAD;
          end else if (go_rx) begin
            tx_mode <= 1'b0;
            bit_cnt <= '0;
            state <= M_LOW;
            tmr <= TMR_RELOAD;
          end
        end
        M_LOW: begin
          if (bit_cnt == BIT_ACK) begin
            sda_oe <= ~tx_mode & ~control_one[C1_NO_ACK];
          end else begin
            sda_oe <= tx_mode & ~shift[7];
          end
          if (tmr_zero) begin
            scl_oe <= 1'b0;
            state <= M_HIGH;
            tmr <= TMR_RELOAD;
          end
        end
        M_HIGH: begin
          if (arb_bit_lost) begin
            // Lost mid-byte: fall back to slave and keep counting in the address byte, else go to S_IGNORE
            scl_oe <= 1'b0;
            shift <= shift_in(shift, sda_s);
            bit_cnt <= bit_cnt + 1'b1;
            state <= addr_phase ? S_ADDR : S_IGNORE;
            ext_phase <= 1'b0;
            cont_pend <= 1'b0;
            addr_phase <= 1'b0;
          end else begin
            if (m_sample && bit_cnt != BIT_ACK) begin
              shift <= shift_in(shift, sda_s);
            end
            if (m_sample && bit_cnt == BIT_ACK && tx_mode) begin
              ack_received_n <= sda_s;
            end
            if (m_high_end) begin
              scl_oe <= 1'b1;
              tmr <= TMR_RELOAD;
              if (bit_cnt == BIT_ACK) begin
                state <= M_WAIT;
                addr_phase <= 1'b0;
                if (!tx_mode) begin
                  rx_data <= shift;
                end
              end else begin
                bit_cnt <= bit_cnt + 1'b1;
                state <= M_LOW;
              end
            end
          end
        end
        M_STOP_A: begin
          scl_oe <= 1'b1;
          sda_oe <= 1'b1;
          if (tmr_zero) begin
            scl_oe <= 1'b0;
            state <= M_STOP_B;
            tmr <= TMR_RELOAD;
          end
        end
        M_STOP_B: begin
          if (scl_s && tmr_zero) begin
            sda_oe <= 1'b0;
            state <= S_IDLE;
          end
        end
        default: begin
          if (stop_det) begin
            state <= S_IDLE;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
          end else if (start_det) begin
            state <= S_ADDR;
            bit_cnt <= '0;
            ext_phase <= 1'b0;
            cont_pend <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
          end else if (state == S_HOLD) begin
            // Clock held low until software moves the next byte
            if (go_tx) begin
              shift <= pwdata[7:0];
              tx_mode <= 1'b1;
              sda_oe <= ~pwdata[7];
              bit_cnt <= '0;
              state <= S_DATA;
            end else if (go_rx) begin
              tx_mode <= 1'b0;
              sda_oe <= 1'b0;
              bit_cnt <= '0;
              state <= S_DATA;
            end
          end else if (state == S_IGNORE) begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
          end else begin
            if (state == S_DATA) begin
              scl_oe <= 1'b0;
            end
            if (scl_rise && bit_cnt < BIT_ACK) begin
              shift <= shift_in(shift, sda_s);
              bit_cnt <= bit_cnt + 1'b1;
            end
            if (scl_rise && bit_cnt == BIT_ACK_END && state == S_DATA && tx_mode) begin
              ack_received_n <= sda_s;
            end
            if (scl_fall && bit_cnt < BIT_ACK && state == S_DATA && tx_mode) begin
              sda_oe <= ~shift[7];
            end
            if (s_fall_ack) begin
              bit_cnt <= BIT_ACK_END;
              if (state == S_DATA) begin
                sda_oe <= ~tx_mode & ~control_one[C1_NO_ACK];
              end else if (addr_hit) begin
                sda_oe <= 1'b1;
                cont_pend <= ten_cont;
                ext_phase <= ten_cont;
              end else begin
                state <= S_IGNORE;
              end
            end
            if (s_fall_end) begin
              sda_oe <= 1'b0;
              if (state == S_ADDR && cont_pend) begin
                cont_pend <= 1'b0;
                bit_cnt <= '0;
              end else if (state == S_DATA && tx_mode && ack_received_n) begin
                state <= S_IGNORE;
              end else begin
                if (state == S_DATA && !tx_mode) begin
                  rx_data <= shift;
                end
                state <= S_HOLD;
                scl_oe <= 1'b1;
              end
            end
          end
        end
      endcase
    end
  end

endmodule // isd_regs_top

// *** verif/isd_i2c_slave.sv ***
module isd_i2c_slave #(
  parameter logic [6:0] ADDR = 7'h52,
  parameter logic [7:0] TX_BYTE = 8'h3C
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic nack,
  input wire logic stretch,
  output logic scl_oe,
  output logic sda_oe,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Byte-level target: acks its address, receives or sends one byte stream
  // ****************************************************************
  int cnt = 99;
  logic first = 1'b0;
  logic rd = 1'b0;
  logic ackbit = 1'b1;
  logic [7:0] sh = 8'h00;

  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    rx_byte = 8'h00;
  end
  always @(negedge sda) if (scl === 1'b1) begin
    cnt = 0;
    first = 1'b1;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    cnt = 99;
    sda_oe = 1'b0;
  end
  always @(posedge scl) begin
    if (cnt < 8) sh = {sh[6:0], sda};
    if (cnt == 8) ackbit = sda;
    cnt = cnt + 1;
  end
  always @(negedge scl) begin
    if (cnt == 8 && first && sh[7:1] != ADDR) cnt = 99;
    else if (cnt == 8) begin
      if (first) rd = sh[0];
      if (first || !rd) rx_byte = sh;
      sda_oe = (first || !rd) && !nack;
      // Slow answer: hold the clock low during the acknowledge slot
      if (stretch) begin
        scl_oe = 1'b1;
        #400;
        scl_oe = 1'b0;
      end
    end else if (cnt == 9) begin
      cnt = (!first && rd && ackbit) ? 99 : 0;
      sda_oe = cnt == 0 && rd && !TX_BYTE[7];
      first = 1'b0;
    end else if (cnt < 8 && rd && !first) sda_oe = !TX_BYTE[7 - cnt];
  end
endmodule // isd_i2c_slave

// *** verif/isd_regs_top_chk.sv ***
module isd_chk
  import isd_pkg::*;
#(
  parameter int unsigned SCL_HALF = SCL_HALF_CYC
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe
);
  // ****************************************************************
  // Shadow state seen through the register bus
  // ****************************************************************
  logic ms;
  logic c1_clean;
  logic irq_seen;
  logic arb_seen;
  wire logic wr_c1 = psel && penable && pwrite && paddr == OFS_CONTROL_ONE;
  wire logic acc_st = psel && penable && paddr == OFS_BUS_STATUS;
  wire logic rd_st = acc_st && !pwrite;
  wire logic wr_st = acc_st && pwrite;
  wire logic rd_c2 = psel && penable && !pwrite && paddr == OFS_CONTROL_TWO;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ms <= 1'b0;
      c1_clean <= 1'b0;
      irq_seen <= 1'b0;
      arb_seen <= 1'b0;
    end else begin
      if (wr_c1) ms <= pwdata[C1_MASTER_SELECT];
      if (wr_c1) c1_clean <= 1'b1;
      else if ($fell(scl_i)) c1_clean <= 1'b0;
      if (wr_st && pwdata[ST_IRQ_PENDING]) irq_seen <= 1'b0;
      else if (rd_st && prdata[ST_IRQ_PENDING]) irq_seen <= 1'b1;
      if (wr_st && pwdata[ST_ARB_LOST]) arb_seen <= 1'b0;
      else if (rd_st && prdata[ST_ARB_LOST]) arb_seen <= 1'b1;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  a_status_rsvd: assert property (rd_st |-> !prdata[ST_UNUSED] && prdata[31:8] == 24'h0)
    else $error("status reserved bits not zero");
  a_c2_rsvd: assert property (rd_c2 |-> prdata[5:3] == 3'h0)
    else $error("control two reserved bits not zero");
  a_start_cond: assert property (wr_c1 && pwdata[C1_MASTER_SELECT] && !ms && !scl_oe && !sda_oe && scl_i && sda_i
    |-> ##[1:3] sda_oe && !scl_oe) else $error("no start after master select");
  a_start_hold: assert property ($rose(sda_oe) && !scl_oe && scl_i |=> !scl_oe [*8])
    else $error("clock pulled too early after start");
  a_stop_cond: assert property (wr_c1 && !pwdata[C1_MASTER_SELECT] && ms
    |-> ##[1:300] $fell(sda_oe) && !scl_oe && scl_i) else $error("no stop after master release");
  a_addr_clear: assert property (rd_st && c1_clean |-> !prdata[ST_SLAVE_ADDRESSED])
    else $error("addressed flag survived control one write");
  a_irq_sticky: assert property (rd_st && irq_seen |-> prdata[ST_IRQ_PENDING])
    else $error("pending flag cleared without write");
  a_arb_sticky: assert property (rd_st && arb_seen |-> prdata[ST_ARB_LOST])
    else $error("arbitration flag cleared without write");

  c_start: cover property (wr_c1 && pwdata[C1_MASTER_SELECT]);
  c_irq: cover property (rd_st && prdata[ST_IRQ_PENDING]);
  c_addressed: cover property (rd_st && prdata[ST_SLAVE_ADDRESSED]);
  c_arb: cover property (rd_st && prdata[ST_ARB_LOST]);
endmodule // isd_chk

// *** verif/tb_isd_regs_top.sv ***
module tb_isd_regs_top
  import isd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SH = 10;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, p_scl_oe, p_sda_oe, perr;
  logic bm_scl_oe = 1'b0, bm_sda_oe = 1'b0, nack = 1'b0, stretch = 1'b0;
  logic [7:0] p_rx;
  int errors = 0;
  int total_checks = 0;
  wire scl = ~((scl_oe & ~scl_o) | bm_scl_oe | p_scl_oe);
  wire sda = ~((sda_oe & ~sda_o) | bm_sda_oe | p_sda_oe);

  always #4 core_clk = ~core_clk;

  isd_regs_top #(.SCL_HALF(SH)) uut (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
  isd_i2c_slave peer (.scl(scl), .sda(sda), .nack(nack), .stretch(stretch), .scl_oe(p_scl_oe),
    .sda_oe(p_sda_oe), .rx_byte(p_rx));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task end_sim;
    $display("errors=%0d checks=%0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task miss(input string m);
    errors++;
    $display("MISMATCH %0t %s", $time, m);
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
    total_checks++;
    if ((got & m) !== (exp & m)) miss($sformatf("got %h exp %h", got, exp));
  endtask
  task q(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      miss("bus hang");
      end_sim();
    end
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    apb(1'b0, a, 8'h00);
    chk(rdat[7:0], e, m);
  endtask
  task wait_done;
    int n;
    for (n = 0; n < 300; n++) begin
      apb(1'b0, OFS_BUS_STATUS, 8'h00);
      if (rdat[ST_XFER_DONE] === 1'b1) break;
    end
    if (n == 300) begin
      miss("done timeout");
      end_sim();
    end
  endtask
  // One bit from the bench master, 80 ns period; returns the line level at the end of the high phase
  task bm_bit(input logic b, output logic s);
    q(2);
    bm_sda_oe <= ~b;
    q(3);
    bm_scl_oe <= 1'b0;
    q(5);
    s = sda;
    bm_scl_oe <= 1'b1;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_regs;
    rd(OFS_BUS_STATUS, 8'h00, 8'hFF);
    apb(1'b1, OFS_CONTROL_TWO, 8'hFF);
    rd(OFS_CONTROL_TWO, 8'hC7, 8'hFF);
    apb(1'b1, OFS_BUS_STATUS, 8'hFF);
    rd(OFS_BUS_STATUS, 8'h00, 8'hFF);
    rd(8'h14, 8'h00, 8'hFF);
    chk({7'h0, perr}, 8'h01, 8'hFF);
  endtask
  task t_master_tx;
    stretch <= 1'b1;
    apb(1'b1, OFS_CONTROL_ONE, 8'h30);
    q(3 * SH);
    apb(1'b1, OFS_DATA_IO, 8'hA4);
    wait_done;
    chk(rdat[7:0], 8'hA2, 8'hFF);
    chk(p_rx, 8'hA4, 8'hFF);
    apb(1'b1, OFS_BUS_STATUS, 8'h02);
    rd(OFS_BUS_STATUS, 8'hA0, 8'hFF);
    stretch <= 1'b0;
    nack <= 1'b1;
    apb(1'b1, OFS_DATA_IO, 8'h5A);
    rd(OFS_BUS_STATUS, 8'h20, 8'hA0);
    wait_done;
    chk(rdat[7:0], 8'hA3, 8'hFF);
    chk(p_rx, 8'h5A, 8'hFF);
    apb(1'b1, OFS_BUS_STATUS, 8'h02);
    nack <= 1'b0;
    apb(1'b1, OFS_CONTROL_ONE, 8'h00);
    q(6 * SH);
    rd(OFS_BUS_STATUS, 8'h00, 8'h20);
  endtask
  task t_master_rx;
    apb(1'b1, OFS_CONTROL_ONE, 8'h30);
    q(3 * SH);
    apb(1'b1, OFS_DATA_IO, 8'hA5);
    wait_done;
    apb(1'b1, OFS_BUS_STATUS, 8'h02);
    apb(1'b0, OFS_DATA_IO, 8'h00);
    rd(OFS_BUS_STATUS, 8'hA0, 8'hFF);
    apb(1'b1, OFS_CONTROL_ONE, 8'h28);
    apb(1'b0, OFS_DATA_IO, 8'h00);
    wait_done;
    apb(1'b1, OFS_BUS_STATUS, 8'h02);
    apb(1'b1, OFS_CONTROL_ONE, 8'h08);
    rd(OFS_DATA_IO, 8'h3C, 8'hFF);
    q(6 * SH);
    rd(OFS_BUS_STATUS, 8'h00, 8'hA2);
  endtask
  task t_slave(input logic [7:0] c2, input logic [7:0] adr, input logic hit);
    logic a;
    apb(1'b1, OFS_CONTROL_TWO, c2);
    apb(1'b1, OFS_SLAVE_ADDR, 8'h66);
    bm_sda_oe <= 1'b1;
    q(5);
    bm_scl_oe <= 1'b1;
    for (int i = 7; i >= 0; i--) bm_bit(adr[i], a);
    bm_bit(1'b1, a);
    chk({7'h0, a}, {7'h0, ~hit}, 8'h01);
    q(4);
    rd(OFS_BUS_STATUS, hit ? (8'hE2 | {5'h00, adr[0], 2'b00}) : 8'h20, hit ? 8'hFF : 8'hE2);
    apb(1'b1, OFS_CONTROL_ONE, 8'h00);
    rd(OFS_BUS_STATUS, hit ? 8'hA2 : 8'h20, 8'hE2);
    apb(1'b1, OFS_BUS_STATUS, 8'h02);
    bm_sda_oe <= 1'b1;
    bm_scl_oe <= 1'b0;
    apb(1'b0, OFS_DATA_IO, 8'h00);
    q(5);
    bm_sda_oe <= 1'b0;
    q(SH);
    rd(OFS_BUS_STATUS, 8'h00, 8'h20);
  endtask

  // Start while the bus is already busy loses arbitration at once
  task t_arb;
    bm_sda_oe <= 1'b1;
    q(5);
    apb(1'b1, OFS_CONTROL_ONE, 8'h30);
    q(2);
    rd(OFS_BUS_STATUS, 8'h32, 8'hFF);
    rd(OFS_CONTROL_ONE, 8'h10, 8'hFF);
    apb(1'b1, OFS_BUS_STATUS, 8'h12);
    bm_sda_oe <= 1'b0;
    q(SH);
    rd(OFS_BUS_STATUS, 8'h00, 8'hFF);
  endtask

  initial begin
    q(12);
    srst <= 1'b0;
    t_regs;
    t_master_tx;
    t_master_rx;
    t_slave(8'h00, 8'h00, 1'b0);
    t_slave(8'h80, 8'h00, 1'b1);
    t_slave(8'h40, 8'h66, 1'b0);
    t_slave(8'h00, 8'h67, 1'b1);
    t_slave(8'h00, 8'h66, 1'b1);
    t_arb;
    end_sim;
  end
endmodule // tb_isd_regs_top

bind isd_regs_top isd_chk #(.SCL_HALF(SCL_HALF)) chk_i (.core_clk(core_clk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe));
